/* File: design/chain_address_and_status_summary.v */
/*
  Chain position field, address unlock flag and primary alert summary
  register of a daisy-chained battery acquisition device.
  Assumes the link front end decodes enumeration commands and register
  writes into one-cycle pulses on CORE_CLK; alert sources are on the
  same clock except where noted as asynchronous.
*/
// Notes on behaviour
// - five-bit chain position loads only from enumeration command address
// - upward enumeration: take received address, forward it plus one
// - downward enumeration: take received address, forward it minus one
// - writes ignored; enumeration updates position only while unlock is set
// - software power-on reset leaves chain position unchanged
// - sixteen-bit primary summary register at offset 0x2, readable and writable
// - reset indication bit 14 set by power-on reset, others reset zero
// - bit 14 clears only on written zero; all other bits read-only
// - scan-done bit 15 follows the scan control done flag
// - mismatch bit set when max minus min exceeds threshold, acquisition-cleared
// - bit 12 ORs fourteen adc and fourteen comparator overvoltage alerts
// - overvoltage summary stays set until an acquisition resolves all
// - bit 11 ORs undervoltage alerts, clears when acquisition resolves all
// - bit 10 set on block overvoltage, cleared at next clean block acquisition
// - bit 9 set on block undervoltage, cleared at next clean block acquisition
// - bits 8 to 0 are read-only summaries from their source groups
// - unlock flag bit 15 cleared only by enumeration, zero writes ignored
`include "chain_status_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module chain_address_and_status_summary #(
  parameter CELLS = 14,
  parameter VW = 14
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  // software power-on reset request, one-cycle pulse
  input wire SW_POR,
  // enumeration command from the link
  input wire ENUM_VALID,
  input wire ENUM_DOWN,
  input wire [4:0] ENUM_ADDR_IN,
  output reg ENUM_FWD_VALID,
  output reg [4:0] ENUM_ADDR_OUT,
  // register access
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  output reg [15:0] REG_RDATA,
  output reg REG_ERR,
  // acquisition results
  input wire SCAN_DONE_FLAG,
  input wire ACQ_DONE,
  input wire [VW-1:0] CELL_MAX,
  input wire [VW-1:0] CELL_MIN,
  input wire [VW-1:0] MISMATCH_THRESHOLD,
  input wire [CELLS-1:0] ADC_CELL_OVER_ALERTS,
  input wire [CELLS-1:0] COMPARATOR_CELL_OVER_ALERTS,
  input wire [CELLS-1:0] ADC_CELL_UNDER_ALERTS,
  input wire [CELLS-1:0] COMPARATOR_CELL_UNDER_ALERTS,
  input wire BLOCK_ACQ_DONE,
  input wire [VW-1:0] BLOCK_VOLTAGE,
  input wire [VW-1:0] BLOCK_OVER_THRESHOLD,
  input wire [VW-1:0] BLOCK_UNDER_THRESHOLD,
  // other summary sources, asynchronous levels
  input wire [8:0] LOW_SUMMARY_SRC,
  // state views
  output wire [4:0] CHAIN_POSITION,
  output wire ADDRESS_UNLOCK_FLAG,
  output wire [15:0] PRIMARY_ALERT_SUMMARY
);

  reg [4:0] chain_position;
  reg address_unlock_flag;
  reg scan_done_alert;
  reg reset_seen_alert;
  reg cell_mismatch_alert;
  reg cell_over_summary;
  reg cell_under_summary;
  reg block_over_alert;
  reg block_under_alert;
  reg [8:0] low_meta;
  reg [8:0] low_sync;
  wire [15:0] summary;
  wire wr_address;
  wire wr_summary;
  wire over_now;
  wire under_now;
  wire mismatch_now;

  assign wr_address = REG_WR && (REG_ADDR == `OFS_ADDRESS);
  assign wr_summary = REG_WR && (REG_ADDR == `OFS_SUMMARY);

  assign over_now = |ADC_CELL_OVER_ALERTS | |COMPARATOR_CELL_OVER_ALERTS;
  assign under_now = |ADC_CELL_UNDER_ALERTS | |COMPARATOR_CELL_UNDER_ALERTS;
  assign mismatch_now = (CELL_MAX > CELL_MIN) &&
    ((CELL_MAX - CELL_MIN) > MISMATCH_THRESHOLD);

  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      chain_position <= `ADDR_POS_RESET;
      address_unlock_flag <= 1'b1;
    end else begin
      if (ENUM_VALID && address_unlock_flag) begin
        chain_position <= ENUM_ADDR_IN;
      end
      if (ENUM_VALID) begin
        address_unlock_flag <= 1'b0;
      end else if (wr_address && REG_WDATA[`ADDR_UNLOCK_BIT]) begin
        address_unlock_flag <= 1'b1;
      end
      // no SW_POR term here
      // soft reset must not touch position or unlock
    end
  end

  // forwarded enumeration address
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ENUM_FWD_VALID <= 1'b0;
      ENUM_ADDR_OUT <= 5'h00;
    end else begin
      ENUM_FWD_VALID <= ENUM_VALID;
      if (ENUM_VALID) begin
        if (ENUM_DOWN) begin
          ENUM_ADDR_OUT <= ENUM_ADDR_IN - 5'h01;
        end else begin
          ENUM_ADDR_OUT <= ENUM_ADDR_IN + 5'h01;
        end
      end
    end
  end

  // low summary sources cross in through two flops
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_meta <= 9'h000;
      low_sync <= 9'h000;
    end else begin
      low_meta <= LOW_SUMMARY_SRC;
      low_sync <= low_meta;
    end
  end

  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scan_done_alert <= 1'b0;
      reset_seen_alert <= 1'b1;
      cell_mismatch_alert <= 1'b0;
      cell_over_summary <= 1'b0;
      cell_under_summary <= 1'b0;
      block_over_alert <= 1'b0;
      block_under_alert <= 1'b0;
    end else begin
      scan_done_alert <= SCAN_DONE_FLAG;
      if (SW_POR) begin
        reset_seen_alert <= 1'b1;
      end else if (wr_summary && !REG_WDATA[`SUM_RESET_BIT]) begin
        reset_seen_alert <= 1'b0;
      end
      if (mismatch_now && ACQ_DONE) begin
        cell_mismatch_alert <= 1'b1;
      end else if (ACQ_DONE) begin
        cell_mismatch_alert <= 1'b0;
      end
      // set on alert, clear at resolving acquisition
      if (over_now) begin
        cell_over_summary <= 1'b1;
      end else if (ACQ_DONE) begin
        cell_over_summary <= 1'b0;
      end
      if (under_now) begin
        cell_under_summary <= 1'b1;
      end else if (ACQ_DONE) begin
        cell_under_summary <= 1'b0;
      end
      if (BLOCK_ACQ_DONE) begin
        block_over_alert <= (BLOCK_VOLTAGE > BLOCK_OVER_THRESHOLD);
      end
      if (BLOCK_ACQ_DONE) begin
        block_under_alert <= (BLOCK_VOLTAGE < BLOCK_UNDER_THRESHOLD);
      end
    end
  end

  assign summary = {scan_done_alert, reset_seen_alert, cell_mismatch_alert,
    cell_over_summary, cell_under_summary, block_over_alert,
    block_under_alert, low_sync};

  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 16'h0000;
      REG_ERR <= 1'b0;
    end else begin
      REG_ERR <= 1'b0;
      if (REG_RD) begin
        case (REG_ADDR)
          `OFS_ADDRESS: begin
            REG_RDATA <= {address_unlock_flag, 10'h000, chain_position};
          end
          `OFS_SUMMARY: begin
            REG_RDATA <= summary;
          end
          default: begin
            REG_RDATA <= 16'h0000;
            REG_ERR <= 1'b1;
          end
        endcase
      end
    end
  end

  assign CHAIN_POSITION = chain_position;
  assign ADDRESS_UNLOCK_FLAG = address_unlock_flag;
  assign PRIMARY_ALERT_SUMMARY = summary;

endmodule // chain_address_and_status_summary

`default_nettype wire

/* File: design/chain_status_consts.vh */
/*
  Constants for the chain position and primary alert summary logic.
  Assumes inclusion by the register bank module only.
*/
`ifndef CHAIN_STATUS_CONSTS_VH
`define CHAIN_STATUS_CONSTS_VH

// register offsets
`define OFS_ADDRESS 8'h01
`define OFS_SUMMARY 8'h02

// address register fields
`define ADDR_UNLOCK_BIT 15
`define ADDR_POS_MSB 4
`define ADDR_POS_RESET 5'h00

// summary register fields
`define SUM_SCAN_BIT 15
`define SUM_RESET_BIT 14
`define SUM_MISMATCH_BIT 13
`define SUM_CELL_OV_BIT 12
`define SUM_CELL_UV_BIT 11
`define SUM_BLK_OV_BIT 10
`define SUM_BLK_UV_BIT 9
`define SUM_RESET_VALUE 16'h4000

`endif

/* File: sim/chain_status_sva.sv */
/* Assertions on chain position and summary ports.
   Assumes one clock and an async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module chain_status_sva (
  // watched ports
  input wire logic CORE_CLK, RST_N, SW_POR, ENUM_VALID, ENUM_DOWN,
  input wire logic ENUM_FWD_VALID, REG_WR, SCAN_DONE_FLAG,
  input wire logic ADDRESS_UNLOCK_FLAG,
  input wire logic [4:0] ENUM_ADDR_IN, ENUM_ADDR_OUT, CHAIN_POSITION,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA, PRIMARY_ALERT_SUMMARY
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_fwd; ENUM_VALID ##1 ENUM_FWD_VALID; endsequence
  property p_fwd; ENUM_VALID |-> s_fwd; endproperty
  a_fwd: assert property (p_fwd) else $error("no forward");
  property p_up; ENUM_VALID && !ENUM_DOWN |=>
    ENUM_ADDR_OUT == $past(ENUM_ADDR_IN) + 5'h01; endproperty
  a_up: assert property (p_up) else $error("bad up address");
  property p_dn; ENUM_VALID && ENUM_DOWN |=>
    ENUM_ADDR_OUT == $past(ENUM_ADDR_IN) - 5'h01; endproperty
  a_dn: assert property (p_dn) else $error("bad down address");
  property p_load; ENUM_VALID && ADDRESS_UNLOCK_FLAG |=>
    CHAIN_POSITION == $past(ENUM_ADDR_IN) && !ADDRESS_UNLOCK_FLAG;
  endproperty
  a_load: assert property (p_load) else $error("no load");
  property p_keep; !ENUM_VALID |=> $stable(CHAIN_POSITION); endproperty
  a_keep: assert property (p_keep) else $error("position moved");
  property p_por; SW_POR && !ENUM_VALID |=>
    PRIMARY_ALERT_SUMMARY[14] && $stable(CHAIN_POSITION); endproperty
  a_por: assert property (p_por) else $error("bad soft reset");
  property p_clr; REG_WR && REG_ADDR == 8'h02 && !REG_WDATA[14] && !SW_POR
    |=> !PRIMARY_ALERT_SUMMARY[14]; endproperty
  a_clr: assert property (p_clr) else $error("bit 14 kept");
  property p_scan; 1'b1 |=>
    PRIMARY_ALERT_SUMMARY[15] == $past(SCAN_DONE_FLAG); endproperty
  a_scan: assert property (p_scan) else $error("scan bit wrong");
endmodule // chain_status_sva
bind chain_address_and_status_summary chain_status_sva u_sva (.*);
`default_nettype wire

/* File: sim/chain_neighbor_model.sv */
/* Next device up the chain, latching the forwarded address.
   Assumes a one-cycle forward pulse on the block clock. */
`timescale 1ns/1ps
`default_nettype none
module chain_neighbor_model (
  // link from the block
  input wire logic clk,
  input wire logic fwd_valid,
  input wire logic [4:0] addr_in,
  // position this device took
  output logic [4:0] own_pos
);
  always @(posedge clk) begin
    if (fwd_valid)
      own_pos <= addr_in;
  end
endmodule // chain_neighbor_model
`default_nettype wire

/* File: sim/tb.sv */
/* Self-checking bench for the chain position and summary block.
   Assumes read data one cycle after the read edge. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, rst_n = 0, por = 0, ev = 0, dn = 0, wr = 0, rd = 0;
  logic scan = 0, acq = 0, fv, err, unl;
  logic [4:0] ain = 0, aout, pos, nb;
  logic [7:0] ra = 0;
  logic [15:0] wd = 0, rdat, sum;
  logic [13:0] mx = 0, mn = 0, bv = 0, ao = 0, co = 0, au = 0, cu = 0;
  logic [8:0] lo = 0;
  int fail_count = 0, checks_done = 0, cyc = 0;
  typedef struct {logic s, sc; logic [13:0] ov, uv, mx, mn, b;
    logic [8:0] l; logic [15:0] e;} row_t;
  row_t rows[4] = '{'{0, 0, 0, 0, 0, 0, 0, 0, 16'h0200},
    '{0, 1, 14'h2000, 14'h0400, 14'h1f4, 14'h12c, 14'h5dc, 9'h1ff, 16'hbdff},
    '{1, 0, 0, 14'h0001, 14'h190, 14'h190, 14'h064, 9'h0a5, 16'h0aa5},
    '{1, 0, 14'h0001, 0, 14'h258, 14'h1f4, 14'h3e8, 0, 16'h1000}};
  chain_address_and_status_summary uut (.CORE_CLK(clk), .RST_N(rst_n),
    .SW_POR(por), .ENUM_VALID(ev), .ENUM_DOWN(dn), .ENUM_ADDR_IN(ain),
    .ENUM_FWD_VALID(fv), .ENUM_ADDR_OUT(aout), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(ra), .REG_WDATA(wd), .REG_RDATA(rdat), .REG_ERR(err),
    .SCAN_DONE_FLAG(scan), .ACQ_DONE(acq), .CELL_MAX(mx), .CELL_MIN(mn),
    .MISMATCH_THRESHOLD(14'h064), .ADC_CELL_OVER_ALERTS(ao),
    .COMPARATOR_CELL_OVER_ALERTS(co), .ADC_CELL_UNDER_ALERTS(au),
    .COMPARATOR_CELL_UNDER_ALERTS(cu), .BLOCK_ACQ_DONE(acq),
    .BLOCK_VOLTAGE(bv), .BLOCK_OVER_THRESHOLD(14'h3e8),
    .BLOCK_UNDER_THRESHOLD(14'h0c8), .LOW_SUMMARY_SRC(lo),
    .CHAIN_POSITION(pos), .ADDRESS_UNLOCK_FLAG(unl),
    .PRIMARY_ALERT_SUMMARY(sum));
  chain_neighbor_model nbr (.clk(clk), .fwd_valid(fv), .addr_in(aout),
    .own_pos(nb));
  initial forever #50 clk = ~clk;
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [15:0] d);
    @(negedge clk) wr = 1;
    ra = a;
    wd = d;
    @(negedge clk) wr = 0;
  endtask
  task automatic rreg(logic [7:0] a, logic [15:0] e);
    @(negedge clk) rd = 1;
    ra = a;
    @(negedge clk) rd = 0;
    chk("read data", e, rdat);
  endtask
  task automatic en(logic d, logic [4:0] a, e, p);
    @(negedge clk) ev = 1;
    dn = d;
    ain = a;
    @(negedge clk) ev = 0;
    chk("enum", {fv, aout, pos, unl}, {1'b1, e, p, 1'b0});
    @(negedge clk);
    chk("neighbour", e, nb);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      test_done;
    end
  end
  initial begin
    row_t r;
    repeat (4) @(posedge clk);
    @(negedge clk) rst_n = 1;
    rreg(8'h02, 16'h4000);
    wreg(8'h02, 16'hffff);
    rreg(8'h02, 16'h4000);
    wreg(8'h02, 16'h0000);
    foreach (rows[i]) begin
      r = rows[i];
      @(negedge clk) acq = 1;
      {scan, mx, mn, bv, lo} = {r.sc, r.mx, r.mn, r.b, r.l};
      {ao, co} = r.s ? {14'h0, r.ov} : {r.ov, 14'h0};
      {au, cu} = r.s ? {r.uv, 14'h0} : {14'h0, r.uv};
      @(negedge clk) acq = 0;
      repeat (3) @(negedge clk);
      rreg(8'h02, r.e);
      chk("summary view", r.e, sum);
    end
    @(negedge clk) por = 1;
    @(negedge clk) por = 0;
    rreg(8'h02, 16'h5000);
    wreg(8'h02, 16'h4000);
    rreg(8'h02, 16'h5000);
    en(0, 5'h1e, 5'h1f, 5'h1e);
    en(1, 5'h03, 5'h02, 5'h1e);
    wreg(8'h01, 16'h0000);
    rreg(8'h01, 16'h001e);
    wreg(8'h01, 16'h8005);
    rreg(8'h01, 16'h801e);
    en(1, 5'h01, 5'h00, 5'h01);
    @(negedge clk) rd = 1;
    ra = 8'h7f;
    @(negedge clk) rd = 0;
    chk("unmapped", 16'h0001, {15'h0, err});
    @(negedge clk) rst_n = 0;
    co = 0;
    @(negedge clk) rst_n = 1;
    chk("reset view", 16'h0001, {pos, unl});
    rreg(8'h02, 16'h4000);
    test_done;
  end
endmodule // tb
`default_nettype wire
